// ### rtl/psc_sram_ctrl.sv
// Behaviour
// (RQ1) burst counter serves four beats per address
// (RQ2) advance high ignores selects, steps counter
// (RQ3) controller drives valid lane selects every beat
// (RQ4) sleep overrides inputs, data lines tri-stated
// (RQ5) two cycles to enter and leave sleep
// (RQ6) array contents untouched while asleep
// (RQ7) accesses pending at sleep entry are dropped
// (RQ8) controller deselects around sleep and recovery
// (RQ9) controller deselects before requesting sleep
// (RQ10) order pin high: interleaved low address bits
// (RQ11) order pin low: linear wrapping low bits
// (RQ12) selected load with write high starts read
// (RQ13) advance in read burst reads next address
// (RQ14) read without output drive stays tri-stated
// (RQ15) selected load with write low starts write
// (RQ16) no lanes selected stores nothing, still advances
// (RQ17) qualifier high freezes state and address
// (RQ18) any write cycle tri-states all data lines
// (RQ19) comes up deselected with lines tri-stated
// (RQ20) output drive masked during writes and deselects
// (RQ21) read data drives after following clock rise
// (RQ22) deselect tri-states after next clock rise
// (RQ23) write data captured second rise after address
// (RQ24) burst alters only two lowest address bits
`timescale 1ns/10ps
`default_nettype none
module psc_sram_ctrl
    import psc_pkg::*;
#(
    parameter int AW = ADDR_W
) (
    input wire logic ref_clk, // system clock
    input wire logic rst_b, // synchronous reset, active low
    input wire logic [AW-1:0] memAddr, // address pins
    input wire logic chipSelect1N, // chip select 1, active low
    input wire logic chipSelect2, // chip select 2, active high
    input wire logic chipSelect3N, // chip select 3, active low
    input wire logic advanceLoadN, // high advances, low loads
    input wire logic writeEnableN, // low selects a write
    input wire logic [LANES-1:0] byteLaneWriteN, // per-lane write selects, active low
    input wire logic clockQualifierN, // high stalls the clock edge
    input wire logic burstOrder, // high interleaved, low linear
    input wire logic outputDriveN, // output drive control, active low
    input wire logic sleepRequest, // sleep request, active high
    input wire logic [DATA_W-1:0] dataIn, // data pins, input side
    input wire logic [LANES-1:0] parityLinesIn, // parity pins, input side
    output logic [DATA_W-1:0] dataOut, // data pins, output side
    output logic [LANES-1:0] parityLinesOut, // parity pins, output side
    output logic dataDriveN, // pin drive enable, low while driving
    output logic [AW-1:0] coreRdAddr, // array read address
    input wire logic [WORD_W-1:0] coreRdData, // array read word, parity on top
    output logic coreWrEn, // array write strobe
    output logic [AW-1:0] coreWrAddr, // array write address
    output logic [WORD_W-1:0] coreWrData, // array write word, parity on top
    output logic [LANES-1:0] coreByteWr, // array lane write enables
    output logic sleeping // low-power state reached
);

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers: every pin but rst_b passes two flops, so all keep equal latency
    localparam int IN_W = AW + 9 + LANES + DATA_W + LANES;

    logic [IN_W-1:0] pinMeta_ff;
    logic [IN_W-1:0] pinSync_ff;
    logic [AW-1:0] sAddr;
    logic sCs1N, sCs2, sCs3N, sAdvLdN, sWeN, sCqN, sOrder, sOeN, sReq;
    logic [LANES-1:0] sBwN;
    logic [DATA_W-1:0] sDq;
    logic [LANES-1:0] sPar;

    always_ff @(posedge ref_clk) begin
        pinMeta_ff <= {memAddr, chipSelect1N, chipSelect2, chipSelect3N, advanceLoadN,
                       writeEnableN, clockQualifierN, burstOrder, outputDriveN, sleepRequest,
                       byteLaneWriteN, dataIn, parityLinesIn};
        pinSync_ff <= pinMeta_ff;
    end

    assign {sAddr, sCs1N, sCs2, sCs3N, sAdvLdN, sWeN, sCqN, sOrder, sOeN, sReq,
            sBwN, sDq, sPar} = pinSync_ff;

    ////////////////////////////////////////////////////////////////////////////
    // sleep sequencing
    psc_sleep_e sleepSt_ff, nxtSleepSt;
    logic [SLEEP_CNT_W-1:0] sleepCnt_ff, nxtSleepCnt;
    logic sleeping_ff;
    logic blocked;
    logic go;

    always_comb begin
        nxtSleepSt = sleepSt_ff;
        nxtSleepCnt = sleepCnt_ff;
        unique case (sleepSt_ff)
            PSC_SLP_AWAKE: begin
                if (sReq) begin
                    nxtSleepSt = PSC_SLP_ENTERING;
                    nxtSleepCnt = SLEEP_CNT_FIRST;
                end
            end
            PSC_SLP_ENTERING: begin
                // (RQ5) entry takes two cycles
                if (!sReq) begin
                    nxtSleepSt = PSC_SLP_WAKING;
                    nxtSleepCnt = SLEEP_CNT_FIRST;
                end else if (sleepCnt_ff >= SLEEP_ENTRY_LAST) begin
                    nxtSleepSt = PSC_SLP_ASLEEP;
                end else begin
                    nxtSleepCnt = SLEEP_CNT_W'(sleepCnt_ff + 3'h1);
                end
            end
            PSC_SLP_ASLEEP: begin
                if (!sReq) begin
                    nxtSleepSt = PSC_SLP_WAKING;
                    nxtSleepCnt = SLEEP_CNT_FIRST;
                end
            end
            PSC_SLP_WAKING: begin
                // (RQ5) exit takes two cycles
                if (sReq) begin
                    nxtSleepSt = PSC_SLP_ENTERING;
                    nxtSleepCnt = SLEEP_CNT_FIRST;
                end else if (sleepCnt_ff >= SLEEP_REC_LAST) begin
                    nxtSleepSt = PSC_SLP_AWAKE;
                end else begin
                    nxtSleepCnt = SLEEP_CNT_W'(sleepCnt_ff + 3'h1);
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            sleepSt_ff <= PSC_SLP_AWAKE;
            sleepCnt_ff <= 3'h0;
            sleeping_ff <= 1'b0;
        end else begin
            sleepSt_ff <= nxtSleepSt;
            sleepCnt_ff <= nxtSleepCnt;
            sleeping_ff <= (nxtSleepSt == PSC_SLP_ASLEEP);
        end
    end

    // (RQ4) a raised request overrides every other input, the stall included
    assign blocked = sReq || (sleepSt_ff != PSC_SLP_AWAKE);
    // (RQ17) qualifier high holds burst and pipeline state; drive control still follows
    assign go = !blocked && !sCqN;

    ////////////////////////////////////////////////////////////////////////////
    // command decode and burst counter
    psc_op_e op_ff, nxtOp;
    logic [BURST_W-1:0] burstCnt_ff, nxtCnt;
    logic [AW-1:0] base_ff, nxtBase, beatAddr;
    logic [BURST_W-1:0] lowBits;
    logic allSel, beatValid, beatWrite;
    logic [LANES-1:0] beatMask;

    assign allSel = !sCs1N && sCs2 && !sCs3N;

    always_comb begin
        nxtOp = op_ff;
        nxtBase = base_ff;
        nxtCnt = BURST_W'(burstCnt_ff + 2'h1);
        beatValid = 1'b0;
        // (RQ10) interleaved order flips bits; (RQ11) linear order wraps
        lowBits = sOrder ? (base_ff[BURST_W-1:0] ^ nxtCnt)
                         : BURST_W'(base_ff[BURST_W-1:0] + nxtCnt);
        // (RQ24) upper bits come only from the loaded base
        beatAddr = {base_ff[AW-1:BURST_W], lowBits};
        if (!sAdvLdN) begin
            nxtCnt = BURST_CNT_RST;
            beatAddr = sAddr;
            if (allSel) begin
                // (RQ12) write high starts a read; (RQ15) write low starts a write
                nxtOp = sWeN ? PSC_OP_READ : PSC_OP_WRITE;
                nxtBase = sAddr;
                beatValid = 1'b1;
            end else begin
                nxtOp = PSC_OP_NONE;
            end
        end else begin
            // (RQ2) advance ignores selects and write enable
            beatValid = (op_ff != PSC_OP_NONE);
        end
        beatWrite = (nxtOp == PSC_OP_WRITE);
        // (RQ3) lanes are taken fresh on every beat
        beatMask = beatWrite ? ~sBwN : 4'h0;
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            op_ff <= PSC_OP_NONE;
            burstCnt_ff <= BURST_CNT_RST;
            base_ff <= '0;
        end else if (blocked) begin
            // (RQ7) whatever burst was open is dropped
            op_ff <= PSC_OP_NONE;
        end else if (go) begin
            // (RQ1) counter steps per beat
            op_ff <= nxtOp;
            burstCnt_ff <= nxtCnt;
            base_ff <= nxtBase;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // access pipeline: stage 1 holds the beat, stage 2 waits for write data
    logic s1Valid_ff, s1Write_ff, s2Valid_ff;
    logic [LANES-1:0] s1Mask_ff, s2Mask_ff;
    logic [AW-1:0] s1Addr_ff, s2Addr_ff, coreRdAddr_ff;

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            s1Valid_ff <= 1'b0;
            s1Write_ff <= 1'b0;
            s2Valid_ff <= 1'b0;
            s1Mask_ff <= 4'h0;
            s2Mask_ff <= 4'h0;
            s1Addr_ff <= '0;
            s2Addr_ff <= '0;
        end else if (blocked) begin
            s1Valid_ff <= 1'b0;
            s2Valid_ff <= 1'b0;
        end else if (go) begin
            s1Valid_ff <= beatValid;
            s1Write_ff <= beatWrite;
            s1Mask_ff <= beatMask;
            s1Addr_ff <= beatAddr;
            s2Valid_ff <= s1Valid_ff && s1Write_ff;
            s2Mask_ff <= s1Mask_ff;
            s2Addr_ff <= s1Addr_ff;
        end
    end

    // (RQ13) each read beat presents its address to the array
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            coreRdAddr_ff <= '0;
        end else if (go && beatValid && !beatWrite) begin
            coreRdAddr_ff <= beatAddr;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // output register and drive control
    logic [WORD_W-1:0] outWord_ff;
    logic outRead_ff, driveN_ff;

    always_ff @(posedge ref_clk) begin
        // (RQ19) reset leaves the pins undriven
        if (!rst_b) begin
            outWord_ff <= '0;
            outRead_ff <= 1'b0;
            driveN_ff <= 1'b1;
        end else if (blocked) begin
            // (RQ4) no drive while sleeping
            outRead_ff <= 1'b0;
            driveN_ff <= 1'b1;
        end else if (go) begin
            // (RQ21) data loaded here is on the pins after this edge
            if (s1Valid_ff && !s1Write_ff) begin
                outWord_ff <= coreRdData;
            end
            outRead_ff <= s1Valid_ff && !s1Write_ff;
            // (RQ18) (RQ20) (RQ22) writes, deselects and gaps float the pins
            driveN_ff <= !(s1Valid_ff && !s1Write_ff && !sOeN);
        end else begin
            // (RQ14) drive control still follows during a stall
            driveN_ff <= !(outRead_ff && !sOeN);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // array write port
    logic coreWrEn_ff;
    logic [AW-1:0] coreWrAddr_ff;
    logic [WORD_W-1:0] coreWrData_ff;
    logic [LANES-1:0] coreByteWr_ff;

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            coreWrEn_ff <= 1'b0;
            coreWrAddr_ff <= '0;
            coreWrData_ff <= '0;
            coreByteWr_ff <= 4'h0;
        end else begin
            // (RQ6) (RQ16) (RQ23) store only lanes selected, never while asleep
            coreWrEn_ff <= go && s2Valid_ff && (|s2Mask_ff);
            if (go) begin
                coreWrAddr_ff <= s2Addr_ff;
                coreWrData_ff <= {sPar, sDq};
                coreByteWr_ff <= s2Mask_ff;
            end
        end
    end

    assign dataOut = outWord_ff[DATA_W-1:0];
    assign parityLinesOut = outWord_ff[WORD_W-1:DATA_W];
    assign dataDriveN = driveN_ff;
    assign coreRdAddr = coreRdAddr_ff;
    assign coreWrEn = coreWrEn_ff;
    assign coreWrAddr = coreWrAddr_ff;
    assign coreWrData = coreWrData_ff;
    assign coreByteWr = coreByteWr_ff;
    assign sleeping = sleeping_ff;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    chk_advance_step: assert property ( // RQ2
        (go && sAdvLdN && op_ff != PSC_OP_NONE)
        |=> burstCnt_ff == BURST_W'($past(burstCnt_ff) + 2'h1))
        else $error("burst counter did not step on advance");

    chk_upper_bits_hold: assert property ( // RQ24
        (go && sAdvLdN && op_ff == PSC_OP_READ)
        |=> coreRdAddr_ff[AW-1:BURST_W] == $past(base_ff[AW-1:BURST_W]))
        else $error("burst changed upper address bits");

    chk_interleave_order: assert property ( // RQ10
        (go && sAdvLdN && sOrder && op_ff == PSC_OP_READ)
        |=> coreRdAddr_ff[1:0] == ($past(base_ff[1:0]) ^ $past(nxtCnt)))
        else $error("interleaved burst address wrong");

    chk_linear_order: assert property ( // RQ11
        (go && sAdvLdN && !sOrder && op_ff == PSC_OP_READ)
        |=> coreRdAddr_ff[1:0] == BURST_W'($past(base_ff[1:0]) + $past(nxtCnt)))
        else $error("linear burst address wrong");

    chk_stall_hold: assert property ( // RQ17
        (!blocked && sCqN) |=> $stable(burstCnt_ff) && $stable(coreRdAddr_ff)
        && $stable(s1Valid_ff) && !coreWrEn_ff)
        else $error("state moved on a stalled edge");

    chk_read_drive: assert property ( // RQ21
        (go && !sAdvLdN && allSel && sWeN) ##1 (go && !sOeN) |=> !driveN_ff)
        else $error("read data not driven after next rise");

    chk_dummy_read: assert property ( // RQ14
        (s1Valid_ff && !s1Write_ff && sOeN) |=> driveN_ff)
        else $error("dummy read drove the pins");

    chk_write_tristate: assert property ( // RQ18
        (s1Valid_ff && s1Write_ff && !sCqN) |=> driveN_ff)
        else $error("pins driven during a write");

    chk_deselect_float: assert property ( // RQ22
        (go && !sAdvLdN && !allSel) ##1 go |=> driveN_ff)
        else $error("deselect did not float the pins");

    chk_write_capture: assert property ( // RQ23
        (go && beatValid && beatWrite && (|beatMask)) ##1 go ##1 go
        |=> coreWrEn_ff && coreByteWr_ff == $past(s2Mask_ff))
        else $error("write beat not stored at second rise");

    chk_empty_mask: assert property ( // RQ16
        coreWrEn_ff |-> (|coreByteWr_ff))
        else $error("write issued with no lanes selected");

    chk_sleep_entry: assert property ( // RQ5
        (sleepSt_ff == PSC_SLP_AWAKE && sReq) ##1 sReq |=> sleeping_ff)
        else $error("sleep not reached in two cycles");

    chk_sleep_exit: assert property ( // RQ5
        (sleepSt_ff == PSC_SLP_ASLEEP && !sReq) ##1 !sReq |=> !blocked)
        else $error("sleep not left in two cycles");

    chk_sleep_quiet: assert property ( // RQ4
        sleeping_ff |-> driveN_ff && !coreWrEn_ff)
        else $error("activity while asleep");

    chk_sleep_drop: assert property ( // RQ7
        blocked |=> op_ff == PSC_OP_NONE && !s1Valid_ff)
        else $error("access survived sleep entry");

    cov_read_burst: cover property (
        (go && !sAdvLdN && allSel && sWeN) ##1 (go && sAdvLdN)[*3]);
    cov_write_burst: cover property (
        (go && !sAdvLdN && allSel && !sWeN) ##1 (go && sAdvLdN) ##2 coreWrEn_ff);
    cov_stall_in_burst: cover property (go && sAdvLdN ##1 sCqN ##1 go);
    cov_sleep_cycle: cover property (sleeping_ff ##1 !sleeping_ff ##2 !blocked);

endmodule : psc_sram_ctrl
`default_nettype wire

// ### pkg/psc_pkg.sv
`default_nettype none
package psc_pkg;
    // array geometry: lanes of eight data bits plus one parity bit
    localparam int ADDR_W = 21;
    localparam int LANES = 4;
    localparam int LANE_DATA_W = 8;
    localparam int DATA_W = LANES * LANE_DATA_W;
    localparam int WORD_W = DATA_W + LANES;
    localparam int BURST_W = 2;
    localparam int SLEEP_CNT_W = 3;

    // timing: ref_clk period and the sleep entry and recovery windows
    localparam int TCYC_PS = 5000;
    localparam int SLEEP_ENTRY_TIME_PS = 2 * TCYC_PS;
    localparam int SLEEP_RECOVERY_TIME_PS = 2 * TCYC_PS;
    // entry is a longest time (round down), recovery a least time (round up)
    localparam int SLEEP_ENTRY_CYC_RAW = SLEEP_ENTRY_TIME_PS / TCYC_PS;
    localparam int SLEEP_ENTRY_CYC = (SLEEP_ENTRY_CYC_RAW < 1) ? 1 : SLEEP_ENTRY_CYC_RAW;
    localparam int SLEEP_REC_CYC = (SLEEP_RECOVERY_TIME_PS + TCYC_PS - 1) / TCYC_PS;
    localparam logic [SLEEP_CNT_W-1:0] SLEEP_ENTRY_LAST = SLEEP_CNT_W'(SLEEP_ENTRY_CYC - 1);
    localparam logic [SLEEP_CNT_W-1:0] SLEEP_REC_LAST = SLEEP_CNT_W'(SLEEP_REC_CYC - 1);
    localparam logic [SLEEP_CNT_W-1:0] SLEEP_CNT_FIRST = 3'h1;

    // reset values
    localparam logic [BURST_W-1:0] BURST_CNT_RST = 2'h0;

    typedef enum logic [1:0] {
        PSC_OP_NONE,
        PSC_OP_READ,
        PSC_OP_WRITE
    } psc_op_e;

    typedef enum logic [1:0] {
        PSC_SLP_AWAKE,
        PSC_SLP_ENTERING,
        PSC_SLP_ASLEEP,
        PSC_SLP_WAKING
    } psc_sleep_e;
endpackage : psc_pkg
`default_nettype wire

// ### dv/psc_array_model.sv
`timescale 1ns/10ps
`default_nettype none
module psc_array_model
    import psc_pkg::*;
(
    input wire logic ref_clk, // system clock
    input wire logic [ADDR_W-1:0] rdAddr, // read address
    output logic [WORD_W-1:0] rdData, // read word
    input wire logic wrEn, // write strobe
    input wire logic [ADDR_W-1:0] wrAddr, // write address
    input wire logic [WORD_W-1:0] wrData, // write word
    input wire logic [LANES-1:0] byteWr // lane enables
);
    // small tagged store; an unwritten word reads as a seed of its own address
    logic [WORD_W-1:0] words [64];
    logic [ADDR_W-1:0] tags [64];
    logic [63:0] used = 64'h0;
    logic [WORD_W-1:0] merged;

    function automatic logic [WORD_W-1:0] lookup(input logic [ADDR_W-1:0] a);
        if (used[a[5:0]] && tags[a[5:0]] == a) begin
            return words[a[5:0]];
        end
        return {a[3:0] ^ 4'hA, 11'h3C5, a};
    endfunction : lookup

    always_comb begin
        rdData = lookup(rdAddr);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // unselected lanes kept
    always @(posedge ref_clk) begin
        if (wrEn) begin
            merged = lookup(wrAddr);
            for (int i = 0; i < LANES; i++) begin
                if (byteWr[i]) begin
                    merged[LANE_DATA_W*i +: LANE_DATA_W] = wrData[LANE_DATA_W*i +: LANE_DATA_W];
                    merged[DATA_W+i] = wrData[DATA_W+i];
                end
            end
            words[wrAddr[5:0]] <= merged;
            tags[wrAddr[5:0]] <= wrAddr;
            used[wrAddr[5:0]] <= 1'h1;
        end
    end
endmodule : psc_array_model
`default_nettype wire

// ### dv/psc_sram_ctrl_test.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(what, exp, got) begin \
    checksDone++; \
    if ((got) !== (exp)) begin \
        miscompares++; \
        $display("[ERR] %s expected %h seen %h", what, exp, got); \
    end \
end
module psc_sram_ctrl_test import psc_pkg::*;;
    logic ref_clk = 1'h0;
    logic rst_b = 1'h0;
    logic [ADDR_W-1:0] memAddr = '0;
    logic chipSelect1N = 1'h1;
    logic chipSelect2 = 1'h0;
    logic chipSelect3N = 1'h1;
    logic advanceLoadN = 1'h0;
    logic writeEnableN = 1'h1;
    logic [LANES-1:0] byteLaneWriteN = 4'hF;
    logic clockQualifierN = 1'h0;
    logic burstOrder = 1'h0;
    logic outputDriveN = 1'h0;
    logic sleepRequest = 1'h0;
    logic [DATA_W-1:0] dataIn = '0;
    logic [LANES-1:0] parityLinesIn = 4'h0;
    logic [DATA_W-1:0] dataOut;
    logic [LANES-1:0] parityLinesOut, coreByteWr;
    logic dataDriveN, coreWrEn, sleeping;
    logic [ADDR_W-1:0] coreRdAddr, coreWrAddr;
    logic [WORD_W-1:0] coreRdData, coreWrData, wrBeat;
    logic wrBeatValid = 1'h0;
    int edgeCnt = 0;
    int miscompares = 0;
    int checksDone = 0;
    logic drvLog [2048], wenLog [2048], slpLog [2048];
    logic [WORD_W-1:0] qLog [2048], wdLog [2048];
    logic [ADDR_W-1:0] raLog [2048], waLog [2048];
    logic [LANES-1:0] bwLog [2048];
    logic [WORD_W-1:0] expMem [logic [ADDR_W-1:0]];

    psc_sram_ctrl u_psc_sram_ctrl (
        .ref_clk, .rst_b, .memAddr, .chipSelect1N, .chipSelect2, .chipSelect3N,
        .advanceLoadN, .writeEnableN, .byteLaneWriteN, .clockQualifierN, .burstOrder,
        .outputDriveN, .sleepRequest, .dataIn, .parityLinesIn, .dataOut, .parityLinesOut,
        .dataDriveN, .coreRdAddr, .coreRdData, .coreWrEn, .coreWrAddr, .coreWrData,
        .coreByteWr, .sleeping
    );
    psc_array_model u_psc_array_model (
        .ref_clk, .rdAddr(coreRdAddr), .rdData(coreRdData), .wrEn(coreWrEn),
        .wrAddr(coreWrAddr), .wrData(coreWrData), .byteWr(coreByteWr)
    );

    always #2.5 ref_clk = ~ref_clk;

    // every output is logged by edge number, so checks can name exact cycles
    always @(posedge ref_clk) begin
        edgeCnt <= edgeCnt + 1;
        if (edgeCnt == 1000) begin
            miscompares++;
            tally_and_finish();
        end
    end
    always @(negedge ref_clk) begin
        drvLog[edgeCnt] = dataDriveN;
        wenLog[edgeCnt] = coreWrEn;
        slpLog[edgeCnt] = sleeping;
        qLog[edgeCnt] = {parityLinesOut, dataOut};
        wdLog[edgeCnt] = coreWrData;
        raLog[edgeCnt] = coreRdAddr;
        waLog[edgeCnt] = coreWrAddr;
        bwLog[edgeCnt] = coreByteWr;
    end

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [WORD_W-1:0] expWord(input logic [ADDR_W-1:0] a);
        return expMem.exists(a) ? expMem[a] : {a[3:0] ^ 4'hA, 11'h3C5, a};
    endfunction : expWord

    function automatic logic [ADDR_W-1:0] beatAddr(input logic [ADDR_W-1:0] b,
                                                   input logic ord, input int j);
        return {b[ADDR_W-1:2], ord ? (b[1:0] ^ 2'(j)) : (b[1:0] + 2'(j))};
    endfunction : beatAddr

    // an undriven data bus shows a pattern that flips every cycle
    task automatic tick();
        @(posedge ref_clk);
        #1;
        {parityLinesIn, dataIn} = wrBeatValid ? wrBeat : ~{parityLinesIn, dataIn};
        wrBeatValid = 1'h0;
    endtask : tick

    task automatic pins(input logic sel, adv, we, cq, input logic [LANES-1:0] lanes,
                        input logic [ADDR_W-1:0] a);
        tick();
        chipSelect1N = ~sel;
        chipSelect2 = sel;
        chipSelect3N = ~sel;
        advanceLoadN = adv;
        writeEnableN = we;
        clockQualifierN = cq;
        byteLaneWriteN = lanes;
        memAddr = a;
    endtask : pins

    task automatic idle(input int n);
        repeat (n) pins(1'h0, 1'h0, 1'h1, 1'h0, 4'hF, '0);
    endtask : idle

    task automatic writeBurst(input logic [ADDR_W-1:0] b, input logic ord,
                              input logic [15:0] lanes);
        int k;
        logic [WORD_W-1:0] d [4];
        logic [WORD_W-1:0] w;
        logic [ADDR_W-1:0] a;
        burstOrder = ord;
        outputDriveN = 1'h0;
        idle(1);
        k = edgeCnt + 1;
        for (int t = 0; t < 6; t++) begin
            if (t >= 2) begin
                d[t-2] = {4'(t), 16'hC0DE, 16'(k + t)};
                wrBeat = d[t-2];
                wrBeatValid = 1'h1;
            end
            if (t < 4) begin
                pins(t == 0, t != 0, t != 0, 1'h0, lanes[4*t +: 4], t == 0 ? b : ~b);
            end else begin
                idle(1);
            end
        end
        // one edge past the last drive sample, so its negedge log is filled
        idle(5);
        for (int j = 0; j < 4; j++) begin
            a = beatAddr(b, ord, j);
            `CHK("wen", lanes[4*j +: 4] != 4'hF, wenLog[k+5+j])
            if (lanes[4*j +: 4] != 4'hF) begin
                `CHK("waddr", a, waLog[k+5+j])
                `CHK("lanes", ~lanes[4*j +: 4], bwLog[k+5+j])
                `CHK("wdata", d[j], wdLog[k+5+j])
                w = expWord(a);
                for (int i = 0; i < LANES; i++) begin
                    if (!lanes[4*j+i]) begin
                        w[8*i +: 8] = d[j][8*i +: 8];
                        w[DATA_W+i] = d[j][DATA_W+i];
                    end
                end
                expMem[a] = w;
            end
        end
        for (int j = k + 3; j < k + 10; j++) begin
            `CHK("wdrive", 1'h1, drvLog[j])
        end
    endtask : writeBurst

    task automatic readBurst(input logic [ADDR_W-1:0] b, input logic ord, stall, oe);
        int k;
        int n;
        int s;
        burstOrder = ord;
        outputDriveN = ~oe;
        idle(1);
        k = edgeCnt + 1;
        n = 0;
        for (int t = 0; t < 7; t++) begin
            if (stall && t == 2) begin
                pins(1'h0, 1'h1, 1'h1, 1'h1, 4'hF, ~b);
            end else if (n < 4) begin
                pins(n == 0, n != 0, 1'h1, 1'h0, 4'hF, n == 0 ? b : ~b);
                n++;
            end else begin
                idle(1);
            end
        end
        idle(4);
        for (int j = 0; j < 4; j++) begin
            s = (stall && j > 0) ? k + 1 : k;
            `CHK("raddr", beatAddr(b, ord, j), raLog[s+3+j])
            `CHK("rdrive", ~oe, drvLog[s+4+j])
            if (oe) `CHK("rword", expWord(beatAddr(b, ord, j)), qLog[s+4+j])
        end
        if (stall) begin
            `CHK("held addr", beatAddr(b, ord, 1), raLog[k+4])
            if (oe) `CHK("held word", expWord(b), qLog[k+5])
        end
        `CHK("deselect", 1'h1, drvLog[k+8+stall])
    endtask : readBurst

    task automatic sleepTest(input logic [ADDR_W-1:0] a);
        int k;
        int m;
        outputDriveN = 1'h0;
        idle(2);
        k = edgeCnt + 1;
        tick();
        sleepRequest = 1'h1;
        idle(5);
        pins(1'h1, 1'h0, 1'h0, 1'h0, 4'h0, a);
        pins(1'h1, 1'h0, 1'h1, 1'h0, 4'hF, a);
        idle(4);
        m = edgeCnt + 1;
        tick();
        sleepRequest = 1'h0;
        idle(6);
        `CHK("entry early", 1'h0, slpLog[k+3])
        `CHK("entry", 1'h1, slpLog[k+4])
        `CHK("exit early", 1'h1, slpLog[m+2])
        `CHK("exit", 1'h0, slpLog[m+4])
        for (int j = k + 5; j < m + 4; j++) begin
            `CHK("asleep wen", 1'h0, wenLog[j])
            `CHK("asleep drive", 1'h1, drvLog[j])
        end
        readBurst(a, 1'h0, 1'h0, 1'h1);
    endtask : sleepTest

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checksDone, miscompares);
        if (miscompares == 0 && checksDone > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : tally_and_finish

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) tick();
        rst_b = 1'h1;
        idle(3);
        for (int j = 1; j < 7; j++) begin
            `CHK("boot drive", 1'h1, drvLog[j])
            `CHK("boot sleep", 1'h0, slpLog[j])
        end
        $display("test reset done");
        writeBurst(21'h0F3A5, 1'h0, 16'h5AF0);
        writeBurst(21'h0F3A6, 1'h1, 16'hC30F);
        $display("test write done");
        for (int o = 0; o < 2; o++) begin
            for (int s = 0; s < 4; s++) begin
                readBurst(21'h0F3A4 | 21'(s), o[0], s == 1, 1'h1);
            end
        end
        readBurst(21'h0F3A7, 1'h1, 1'h0, 1'h0);
        $display("test read done");
        sleepTest(21'h12345);
        $display("test sleep done");
        tally_and_finish();
    end
endmodule : psc_sram_ctrl_test
`default_nettype wire
